/* verilog/jtdr_defines.svh */
// Offsets, codes, field positions and the break point count for the test data register block
`ifndef JTDR_DEFINES_SVH
`define JTDR_DEFINES_SVH
`define JTDR_IR_W        4
`define JTDR_OP_EXTEST   4'h0
`define JTDR_OP_IDCODE   4'h1
`define JTDR_OP_SAMPLE   4'h2
`define JTDR_OP_PRIV_A   4'h8
`define JTDR_OP_PRIV_B   4'h9
`define JTDR_OP_PRIV_C   4'hA
`define JTDR_OP_PRIV_D   4'hB
`define JTDR_OP_SYSRST   4'hC
`define JTDR_OP_BYPASS   4'hF
`define JTDR_IR_CAPTURE  4'h1
`define JTDR_ID_VER_LSB  28
`define JTDR_ID_PART_LSB 12
`define JTDR_ID_MFR_LSB  1
`define JTDR_MSG_RESET   8'h00
`define JTDR_BP_COUNT    4
`endif

/* verilog/jtdr_pkg.sv */
// Types shared by the test data register block
package jtdr_pkg;
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} jtdr_tap_t;
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} jtdr_link_t;
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} jtdr_cpu_t;
	typedef enum logic [1:0] {
		BP_FOUR_PROG, BP_PROG_DATA, BP_PROG_RANGE
	} jtdr_bp_mode_t;
endpackage : jtdr_pkg

/* verilog/jtdr_top.sv */
// Test data registers, reset register and debug hooks behind the test access port
//
// Overview of operation
// - Four break points: four program, mix with two data, or two plus masked range.
// - Break on program flow change and single step besides address break points.
// - A CPU write to the message register sets the dirty flag at once.
// - CPU read returns seven stored low bits with the dirty flag on top.
// - Shared location reaches the message register only with fuse and debugger enable.
// - Debug works only with both fuses programmed and no lock bit set.
// - Test port enabled only with its fuse programmed and disable bit zero.
// - With a lock bit set, debug fuse programming is refused until chip erase.
// - Codes 0x8 to 0xB are private debug instructions with undefined data path.
// - After power-up the instruction register holds the identification instruction.
// - Entering reset puts every port output in high impedance a core clock later, except while boundary test is loaded.
// - Loading boundary test drives the output latches onto the pins at once.
// - Boundary scan samples the test clock on the core clock, which must keep running.
// - Bypass is one stage loaded with zero at capture when selected.
// - Identification holds a four-bit version tracking silicon revision from zero.
// - Identification holds a fixed sixteen-bit part number.
// - Identification holds a fixed eleven-bit manufacturer code.
// - A one in the reset register holds the device in reset like the pin.
// - After the reset register clears, reset lasts the fused time-out period.
// - Reset register output feeds reset logic directly with no update latch.
// - The instruction register is four bits wide.
// - Identification instruction selects the 32-bit identification register.
// - System reset instruction selects the one-bit reset register, not the controller.
`timescale 1ns/10ps
`include "jtdr_defines.svh"
module jtdr_top #(
	parameter int          PINS       = 8,
	parameter logic [3:0]  VERSION    = 4'h0,
	parameter logic [15:0] PART_NUM   = 16'h1234,
	parameter logic [10:0] MFR_CODE   = 11'h055,
	parameter int          TIMEOUT_W  = 16
) (
	input  wire logic                jtdr_clk_unused_guard,
	input  wire logic                ref_clk,
	input  wire logic                rst,
	input  wire jtdr_pkg::jtdr_link_t link,
	output logic                     tdo,
	output logic                     tdo_oe,
	input  wire logic                test_port_enable_fuse,
	input  wire logic                debug_enable_fuse,
	input  wire logic                test_port_disable_bit,
	input  wire logic                lock_bit_one,
	input  wire logic                lock_bit_two,
	input  wire logic                debugger_access_en,
	input  wire logic                debugger_clear_dirty,
	input  wire logic                debug_fuse_prog_req,
	input  wire logic                chip_erase,
	input  wire logic [TIMEOUT_W-1:0] reset_timeout,
	input  wire logic                ext_reset_n,
	input  wire jtdr_pkg::jtdr_cpu_t cpu,
	input  wire logic [7:0]          io_rdata,
	output logic [7:0]               cpu_rdata,
	output logic                     io_select,
	output logic                     debug_active,
	output logic                     debug_fuse_prog_ok,
	input  wire jtdr_pkg::jtdr_bp_mode_t bp_mode,
	input  wire logic [`JTDR_BP_COUNT-1:0] bp_hit,
	input  wire logic                flow_change,
	input  wire logic                step_done,
	input  wire logic                break_flow_en,
	input  wire logic                single_step_en,
	output logic                     break_req,
	input  wire logic [PINS-1:0]     pin_in,
	input  wire logic [PINS-1:0]     core_out,
	input  wire logic [PINS-1:0]     core_oe,
	output logic [PINS-1:0]          pin_out,
	output logic [PINS-1:0]          pin_oe,
	output logic                     sys_reset
);
	localparam int BSR_W = 2 * PINS;
	logic [2:0] tck_sync_reg, tck_sync_next;
	logic [1:0] tms_sync_reg, tms_sync_next, tdi_sync_reg, tdi_sync_next;
	logic [1:0] ern_sync_reg, ern_sync_next;
	jtdr_pkg::jtdr_tap_t tap_reg, tap_next;
	logic [3:0]          ir_sh_reg, ir_sh_next, ir_reg, ir_next;
	logic                byp_reg, byp_next, rstdr_reg, rstdr_next;
	logic [31:0]         id_sh_reg, id_sh_next;
	logic [BSR_W-1:0]    bsr_reg, bsr_next, bsr_lat_reg, bsr_lat_next;
	logic                tdo_reg, tdo_next, tdo_oe_reg, tdo_oe_next;
	logic [7:0]          msg_reg, msg_next, rd_reg, rd_next;
	logic                dirty_reg, dirty_next, iosel_reg, iosel_next;
	logic                lock_seen_reg, lock_seen_next, dbg_reg, dbg_next, dfp_reg, dfp_next;
	logic                brk_reg, brk_next, srst_reg, srst_next;
	logic [TIMEOUT_W-1:0] to_cnt_reg, to_cnt_next;
	logic [PINS-1:0]     pout_reg, pout_next, poe_reg, poe_next;
	logic                tck_rise, tms_s, tdi_s, tap_en, dbg_ok, msg_sel, in_reset;
	logic [31:0]         id_word;

	function automatic jtdr_pkg::jtdr_tap_t tap_step(input jtdr_pkg::jtdr_tap_t s, input logic m);
		unique case (s)
			jtdr_pkg::TLR:    tap_step = m ? jtdr_pkg::TLR    : jtdr_pkg::RTI;
			jtdr_pkg::RTI:    tap_step = m ? jtdr_pkg::SEL_DR : jtdr_pkg::RTI;
			jtdr_pkg::SEL_DR: tap_step = m ? jtdr_pkg::SEL_IR : jtdr_pkg::CAP_DR;
			jtdr_pkg::CAP_DR: tap_step = m ? jtdr_pkg::EX1_DR : jtdr_pkg::SH_DR;
			jtdr_pkg::SH_DR:  tap_step = m ? jtdr_pkg::EX1_DR : jtdr_pkg::SH_DR;
			jtdr_pkg::EX1_DR: tap_step = m ? jtdr_pkg::UPD_DR : jtdr_pkg::PA_DR;
			jtdr_pkg::PA_DR:  tap_step = m ? jtdr_pkg::EX2_DR : jtdr_pkg::PA_DR;
			jtdr_pkg::EX2_DR: tap_step = m ? jtdr_pkg::UPD_DR : jtdr_pkg::SH_DR;
			jtdr_pkg::UPD_DR: tap_step = m ? jtdr_pkg::SEL_DR : jtdr_pkg::RTI;
			jtdr_pkg::SEL_IR: tap_step = m ? jtdr_pkg::TLR    : jtdr_pkg::CAP_IR;
			jtdr_pkg::CAP_IR: tap_step = m ? jtdr_pkg::EX1_IR : jtdr_pkg::SH_IR;
			jtdr_pkg::SH_IR:  tap_step = m ? jtdr_pkg::EX1_IR : jtdr_pkg::SH_IR;
			jtdr_pkg::EX1_IR: tap_step = m ? jtdr_pkg::UPD_IR : jtdr_pkg::PA_IR;
			jtdr_pkg::PA_IR:  tap_step = m ? jtdr_pkg::EX2_IR : jtdr_pkg::PA_IR;
			jtdr_pkg::EX2_IR: tap_step = m ? jtdr_pkg::UPD_IR : jtdr_pkg::SH_IR;
			jtdr_pkg::UPD_IR: tap_step = m ? jtdr_pkg::SEL_DR : jtdr_pkg::RTI;
		endcase
	endfunction : tap_step

	// Boundary order: for each pin an output enable cell then a data cell
	function automatic logic [PINS-1:0] bsr_field(input logic [BSR_W-1:0] v, input logic odd);
		logic [PINS-1:0] r;
		r = '0;
		for (int i = 0; i < PINS; i++)
			r[i] = v[2*i + (odd ? 1 : 0)];
		bsr_field = r;
	endfunction : bsr_field

	assign tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
	assign tms_s    = tms_sync_reg[1];
	assign tdi_s    = tdi_sync_reg[1];
	assign tap_en   = test_port_enable_fuse & ~test_port_disable_bit;
	assign dbg_ok   = test_port_enable_fuse & debug_enable_fuse & ~lock_bit_one & ~lock_bit_two;
	assign msg_sel  = debug_enable_fuse & debugger_access_en;
	assign id_word  = {VERSION, PART_NUM, MFR_CODE, 1'b1};
	assign in_reset = rstdr_reg | ~ern_sync_reg[1];

	always_comb
	begin
		tck_sync_next = {tck_sync_reg[1:0], link.tck};
		tms_sync_next = {tms_sync_reg[0], link.tms};
		tdi_sync_next = {tdi_sync_reg[0], link.tdi};
		ern_sync_next = {ern_sync_reg[0], ext_reset_n};
	end

	// Test clock edges are found by sampling the link on the core clock, which must keep running
	always_comb
	begin
		tap_next     = tap_reg;
		ir_sh_next   = ir_sh_reg;
		ir_next      = ir_reg;
		byp_next     = byp_reg;
		rstdr_next   = rstdr_reg;
		id_sh_next   = id_sh_reg;
		bsr_next     = bsr_reg;
		bsr_lat_next = bsr_lat_reg;
		tdo_next     = tdo_reg;
		tdo_oe_next  = tdo_oe_reg;
		if (!tap_en)
		begin
			tap_next    = jtdr_pkg::TLR;
			ir_next     = `JTDR_OP_IDCODE;
			tdo_oe_next = 1'b0;
		end
		else if (tck_rise)
		begin
			tap_next = tap_step(tap_reg, tms_s);
			unique case (tap_reg)
				jtdr_pkg::TLR:
					ir_next = `JTDR_OP_IDCODE;
				jtdr_pkg::CAP_IR:
					ir_sh_next = `JTDR_IR_CAPTURE;
				jtdr_pkg::SH_IR:
					ir_sh_next = {tdi_s, ir_sh_reg[3:1]};
				jtdr_pkg::UPD_IR:
					ir_next = ir_sh_reg;
				jtdr_pkg::CAP_DR:
					unique case (ir_reg)
						`JTDR_OP_IDCODE: id_sh_next = id_word;
						`JTDR_OP_EXTEST, `JTDR_OP_SAMPLE:
							for (int i = 0; i < PINS; i++)
							begin
								bsr_next[2*i]   = poe_reg[i];
								bsr_next[2*i+1] = pin_in[i];
							end
						`JTDR_OP_SYSRST: ;
						default: byp_next = 1'b0;
					endcase
				jtdr_pkg::SH_DR:
					unique case (ir_reg)
						`JTDR_OP_IDCODE: id_sh_next = {tdi_s, id_sh_reg[31:1]};
						`JTDR_OP_EXTEST, `JTDR_OP_SAMPLE: bsr_next = {tdi_s, bsr_reg[BSR_W-1:1]};
						`JTDR_OP_SYSRST: rstdr_next = tdi_s;
						default: byp_next = tdi_s;
					endcase
				jtdr_pkg::UPD_DR:
					if (ir_reg == `JTDR_OP_EXTEST || ir_reg == `JTDR_OP_SAMPLE)
						bsr_lat_next = bsr_reg;
				default: ;
			endcase
			// Output changes on the rising edge; the far side samples it late in the following low phase
			tdo_oe_next = (tap_reg == jtdr_pkg::SH_DR) || (tap_reg == jtdr_pkg::SH_IR) ||
				(tap_next == jtdr_pkg::SH_DR) || (tap_next == jtdr_pkg::SH_IR);
			if (tap_next == jtdr_pkg::SH_IR)
				tdo_next = ir_sh_next[0]; // Capture pattern already sits in the shifter on entry
			else if (tap_next == jtdr_pkg::SH_DR)
				unique case (ir_reg)
					`JTDR_OP_IDCODE: tdo_next = id_sh_next[0];
					`JTDR_OP_EXTEST, `JTDR_OP_SAMPLE: tdo_next = bsr_next[0];
					`JTDR_OP_SYSRST: tdo_next = rstdr_next;
					default: tdo_next = byp_next;
				endcase
		end
	end

	// Debug hooks and message channel
	always_comb
	begin
		msg_next       = msg_reg;
		dirty_next     = dirty_reg;
		rd_next        = rd_reg;
		iosel_next     = ~msg_sel;
		lock_seen_next = lock_seen_reg;
		dbg_next       = dbg_ok;
		brk_next       = 1'b0;
		if (debugger_clear_dirty)
			dirty_next = 1'b0;
		if (cpu.wr && msg_sel)
		begin
			msg_next   = cpu.wdata;
			dirty_next = 1'b1;
		end
		if (cpu.rd)
			rd_next = msg_sel ? {dirty_reg, msg_reg[6:0]} : io_rdata;
		if (chip_erase)
			lock_seen_next = 1'b0;
		if (lock_bit_one || lock_bit_two)
			lock_seen_next = 1'b1;
		dfp_next = debug_fuse_prog_req & ~lock_seen_next;
		if (dbg_ok)
		begin
			unique case (bp_mode)
				jtdr_pkg::BP_FOUR_PROG:  brk_next = |bp_hit;
				jtdr_pkg::BP_PROG_DATA:  brk_next = |bp_hit;
				jtdr_pkg::BP_PROG_RANGE: brk_next = |bp_hit[2:0];
				default:                 brk_next = 1'b0;
			endcase
			if ((break_flow_en && flow_change) || (single_step_en && step_done))
				brk_next = 1'b1;
		end
	end

	// Reset hold and pin drive; the time-out counts core clocks after release
	always_comb
	begin
		srst_next   = srst_reg;
		to_cnt_next = to_cnt_reg;
		if (in_reset)
		begin
			srst_next   = 1'b1;
			to_cnt_next = reset_timeout;
		end
		else if (to_cnt_reg != '0)
			to_cnt_next = to_cnt_reg - 1'b1;
		else
			srst_next = 1'b0;
		if (tap_en && ir_next == `JTDR_OP_EXTEST)
		begin
			pout_next = bsr_field(bsr_lat_next, 1'b1);
			poe_next  = bsr_field(bsr_lat_next, 1'b0);
		end
		else if (in_reset || srst_next)
		begin
			pout_next = '0;
			poe_next  = '0;
		end
		else
		begin
			pout_next = core_out;
			poe_next  = core_oe;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			tck_sync_reg  <= 3'h0;
			tms_sync_reg  <= 2'h3;
			tdi_sync_reg  <= 2'h3;
			ern_sync_reg  <= 2'h3;
			tap_reg       <= jtdr_pkg::TLR;
			ir_sh_reg     <= 4'h0;
			ir_reg        <= `JTDR_OP_IDCODE;
			byp_reg       <= 1'b0;
			rstdr_reg     <= 1'b0;
			id_sh_reg     <= 32'h0;
			bsr_reg       <= '0;
			bsr_lat_reg   <= '0;
			tdo_reg       <= 1'b0;
			tdo_oe_reg    <= 1'b0;
			msg_reg       <= `JTDR_MSG_RESET;
			dirty_reg     <= 1'b0;
			rd_reg        <= 8'h00;
			iosel_reg     <= 1'b1;
			lock_seen_reg <= 1'b0;
			dbg_reg       <= 1'b0;
			dfp_reg       <= 1'b0;
			brk_reg       <= 1'b0;
			srst_reg      <= 1'b1;
			to_cnt_reg    <= '0;
			pout_reg      <= '0;
			poe_reg       <= '0;
		end
		else
		begin
			tck_sync_reg  <= tck_sync_next;
			tms_sync_reg  <= tms_sync_next;
			tdi_sync_reg  <= tdi_sync_next;
			ern_sync_reg  <= ern_sync_next;
			tap_reg       <= tap_next;
			ir_sh_reg     <= ir_sh_next;
			ir_reg        <= ir_next;
			byp_reg       <= byp_next;
			rstdr_reg     <= rstdr_next;
			id_sh_reg     <= id_sh_next;
			bsr_reg       <= bsr_next;
			bsr_lat_reg   <= bsr_lat_next;
			tdo_reg       <= tdo_next;
			tdo_oe_reg    <= tdo_oe_next;
			msg_reg       <= msg_next;
			dirty_reg     <= dirty_next;
			rd_reg        <= rd_next;
			iosel_reg     <= iosel_next;
			lock_seen_reg <= lock_seen_next;
			dbg_reg       <= dbg_next;
			dfp_reg       <= dfp_next;
			brk_reg       <= brk_next;
			srst_reg      <= srst_next;
			to_cnt_reg    <= to_cnt_next;
			pout_reg      <= pout_next;
			poe_reg       <= poe_next;
		end
	end

	assign tdo                = tdo_reg;
	assign tdo_oe             = tdo_oe_reg;
	assign cpu_rdata          = rd_reg;
	assign io_select          = iosel_reg;
	assign debug_active       = dbg_reg;
	assign debug_fuse_prog_ok = dfp_reg;
	assign break_req          = brk_reg;
	assign pin_out            = pout_reg;
	assign pin_oe             = poe_reg;
	assign sys_reset          = srst_reg;
endmodule : jtdr_top

/* verif/jtdr_ctl_model.sv */
// Behavioural boundary-scan controller that drives the test access pins
`timescale 1ns/10ps
module jtdr_ctl_model (
	input  wire logic            ref_clk,
	output jtdr_pkg::jtdr_link_t link,
	input  wire logic            tdo
);
	// Clock parked low between frames, data and mode idle high like the pull-ups
	initial link = 3'b011;

	// One test clock period of 400 ns: four core cycles low, four high
	task automatic clk1(input logic ms, input logic di, output logic so);
		link.tms = ms;
		link.tdi = di;
		repeat (4) @(negedge ref_clk);
		so = tdo; // Sampled late in the low phase, well past the output lag
		link.tck = 1'b1;
		repeat (4) @(negedge ref_clk);
		link.tck = 1'b0;
	endtask : clk1

	task automatic nav(input logic [7:0] seq, input int n);
		logic s;
		for (int i = 0; i < n; i++)
			clk1(seq[i], 1'b1, s);
	endtask : nav

	task automatic reset_tap();
		nav(8'h1F, 6);
	endtask : reset_tap

	// Whole scan from idle back to idle; ir selects the instruction path
	task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
		logic s;
		dout = '0;
		nav(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++)
		begin
			clk1(i == n - 1, din[i], s);
			dout[i] = s;
		end
		nav(8'h01, 2);
	endtask : scan
endmodule : jtdr_ctl_model

/* verif/jtdr_asserts.sv */
// Concurrent checks on the ports of the test data register block
`timescale 1ns/10ps
`include "jtdr_defines.svh"
module jtdr_asserts #(
	parameter int PINS = 8
) (
	input wire logic                       ref_clk,
	input wire logic                       rst,
	input wire jtdr_pkg::jtdr_cpu_t        cpu,
	input wire logic                       debugger_access_en,
	input wire logic                       debug_enable_fuse,
	input wire logic                       test_port_enable_fuse,
	input wire logic                       test_port_disable_bit,
	input wire logic                       lock_bit_one,
	input wire logic                       lock_bit_two,
	input wire logic [7:0]                 io_rdata,
	input wire logic [7:0]                 cpu_rdata,
	input wire logic [`JTDR_BP_COUNT-1:0]  bp_hit,
	input wire logic                       flow_change,
	input wire logic                       break_flow_en,
	input wire logic                       step_done,
	input wire logic                       single_step_en,
	input wire logic                       break_req,
	input wire logic                       debug_active,
	input wire logic                       debug_fuse_prog_ok,
	input wire logic                       tdo_oe,
	input wire logic                       ext_reset_n,
	input wire logic                       sys_reset,
	input wire logic [PINS-1:0]            pin_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	bp_break_a: assert property (bp_hit[0] && test_port_enable_fuse && debug_enable_fuse
		&& !lock_bit_one && !lock_bit_two |=> break_req)
		else $error("break point hit gave no break");
	flow_break_a: assert property (flow_change && break_flow_en && test_port_enable_fuse
		&& debug_enable_fuse && !lock_bit_one && !lock_bit_two |=> break_req)
		else $error("flow change gave no break");
	step_break_a: assert property (step_done && single_step_en && test_port_enable_fuse
		&& debug_enable_fuse && !lock_bit_one && !lock_bit_two |=> break_req)
		else $error("single step gave no break");
	msg_read_a: assert property (cpu.wr && debugger_access_en && debug_enable_fuse ##1
		cpu.rd && debugger_access_en && debug_enable_fuse |=> cpu_rdata == {1'b1, $past(cpu.wdata[6:0], 2)})
		else $error("message read lacks stored bits or dirty flag");
	io_read_a: assert property (cpu.rd && !debugger_access_en |=> cpu_rdata == $past(io_rdata))
		else $error("shared location did not return ordinary data");
	dbg_active_a: assert property (test_port_enable_fuse && debug_enable_fuse
		&& !lock_bit_one && !lock_bit_two |=> debug_active)
		else $error("debug not active with fuses set and no lock");
	lock_block_a: assert property (lock_bit_one || lock_bit_two |=> !debug_active && !debug_fuse_prog_ok)
		else $error("lock bit did not block debug");
	port_off_a: assert property ((test_port_disable_bit || !test_port_enable_fuse) [*3] |-> !tdo_oe)
		else $error("disabled test port drove data out");
	pin_hiz_a: assert property (sys_reset && $past(sys_reset) |-> pin_oe == '0)
		else $error("pin driven while in reset");
	ext_reset_a: assert property (!ext_reset_n |-> ##[0:4] sys_reset)
		else $error("reset pin did not reset the device");
endmodule : jtdr_asserts

bind jtdr_top jtdr_asserts #(.PINS(PINS)) chk_u (.ref_clk, .rst, .cpu, .debugger_access_en, .debug_enable_fuse,
	.test_port_enable_fuse, .test_port_disable_bit, .lock_bit_one, .lock_bit_two, .io_rdata, .cpu_rdata, .bp_hit,
	.flow_change, .break_flow_en, .step_done, .single_step_en, .break_req, .debug_active, .debug_fuse_prog_ok,
	.tdo_oe, .ext_reset_n, .sys_reset, .pin_oe);

/* verif/tb.sv */
// Self-checking testbench for the test data register block
`timescale 1ns/10ps
`include "jtdr_defines.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
	logic ref_clk, rst, jtdr_clk_unused_guard, tdo, tdo_oe, oe_seen;
	logic test_port_enable_fuse, debug_enable_fuse, test_port_disable_bit, lock_bit_one, lock_bit_two;
	logic debugger_access_en, debugger_clear_dirty, debug_fuse_prog_req, chip_erase, ext_reset_n;
	logic io_select, debug_active, debug_fuse_prog_ok, flow_change, step_done, break_flow_en;
	logic single_step_en, break_req, sys_reset;
	logic [15:0] reset_timeout;
	logic [7:0] io_rdata, cpu_rdata, pin_in, core_out, core_oe, pin_out, pin_oe;
	logic [3:0] bp_hit;
	logic [31:0] rd_v;
	jtdr_pkg::jtdr_link_t link;
	jtdr_pkg::jtdr_cpu_t cpu;
	jtdr_pkg::jtdr_bp_mode_t bp_mode;
	int n_errors, compares;

	jtdr_top dut_u (
		.jtdr_clk_unused_guard, .ref_clk, .rst, .link, .tdo, .tdo_oe, .test_port_enable_fuse, .debug_enable_fuse,
		.test_port_disable_bit, .lock_bit_one, .lock_bit_two, .debugger_access_en, .debugger_clear_dirty,
		.debug_fuse_prog_req, .chip_erase, .reset_timeout, .ext_reset_n, .cpu, .io_rdata, .cpu_rdata, .io_select,
		.debug_active, .debug_fuse_prog_ok, .bp_mode, .bp_hit, .flow_change, .step_done, .break_flow_en,
		.single_step_en, .break_req, .pin_in, .core_out, .core_oe, .pin_out, .pin_oe, .sys_reset
	);
	jtdr_ctl_model ctl_u (.ref_clk(ref_clk), .link(link), .tdo(tdo));

	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) if (tdo_oe) oe_seen <= 1'b1;

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc

	task automatic tally_and_finish();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	task automatic cpu_rd(input string nm, input logic [7:0] e);
		cpu = {2'b01, 8'h00};
		cyc(1);
		cpu = '0;
		`CHK(nm, e, cpu_rdata)
		cyc(1);
	endtask : cpu_rd

	task automatic cause(input logic [7:0] c, input logic e);
		{break_flow_en, single_step_en, flow_change, step_done, bp_hit} = c;
		cyc(1);
		{break_flow_en, single_step_en, flow_change, step_done, bp_hit} = '0;
		`CHK("break", e, break_req)
		cyc(1);
		`CHK("break end", 1'b0, break_req)
	endtask : cause

	task automatic t_scan_paths();
		logic [3:0] ops [5] = '{`JTDR_OP_BYPASS, `JTDR_OP_PRIV_A, `JTDR_OP_PRIV_B, `JTDR_OP_PRIV_C, `JTDR_OP_PRIV_D};
		ctl_u.reset_tap();
		ctl_u.scan(0, 32'h0, 32, rd_v);
		`CHK("idcode", {4'h0, 16'h1234, 11'h055, 1'b1}, rd_v)
		for (int k = 0; k < 5; k++)
		begin
			ctl_u.scan(1, {28'h0, ops[k]}, 4, rd_v);
			`CHK("ir capture", 32'h1, rd_v)
			ctl_u.scan(0, 32'h3, 2, rd_v);
			`CHK("bypass", 32'h2, rd_v)
		end
	endtask : t_scan_paths

	task automatic t_reset_reg();
		ctl_u.scan(1, {28'h0, `JTDR_OP_SYSRST}, 4, rd_v);
		ctl_u.scan(0, 32'h1, 1, rd_v);
		`CHK("reset held", 1'b1, sys_reset)
		`CHK("pins off", 8'h00, pin_oe)
		ctl_u.scan(0, 32'h0, 1, rd_v);
		`CHK("reset freed", 1'b0, sys_reset)
	endtask : t_reset_reg

	task automatic t_message();
		debugger_access_en = 1'b1;
		cpu = {2'b10, 8'h25};
		cyc(1);
		cpu_rd("msg dirty", 8'hA5);
		debugger_clear_dirty = 1'b1;
		cyc(1);
		debugger_clear_dirty = 1'b0;
		cpu_rd("msg clean", 8'h25);
		debugger_access_en = 1'b0;
		cpu = {2'b10, 8'h7E};
		cyc(1);
		cpu_rd("io read", 8'hC3);
		`CHK("io select", 1'b1, io_select)
		debugger_access_en = 1'b1;
		cyc(1);
		cpu_rd("msg kept", 8'h25);
		`CHK("msg select", 1'b0, io_select)
	endtask : t_message

	task automatic t_breaks();
		for (int m = 0; m < 3; m++)
		begin
			bp_mode = jtdr_pkg::jtdr_bp_mode_t'(m);
			cause(8'h01, 1'b1);
			cause(8'h02, 1'b1);
			cause(8'h08, m != 2);
		end
		cause(8'hA0, 1'b1);
		cause(8'h20, 1'b0);
		cause(8'h50, 1'b1);
		cause(8'h10, 1'b0);
	endtask : t_breaks

	task automatic t_boundary();
		logic [15:0] cells;
		logic [7:0]  dv;
		int cnt;
		dv = 8'h5A;
		for (int i = 0; i < 8; i++)
			cells[2*i +: 2] = {dv[i], 1'b1};
		`CHK("pins normal", 8'h0F, pin_out)
		`CHK("pins normal oe", 8'hF0, pin_oe)
		ctl_u.scan(1, {28'h0, `JTDR_OP_SAMPLE}, 4, rd_v); // Safe values go in before pins are driven
		ctl_u.scan(0, {16'h0, cells}, 16, rd_v);
		`CHK("sample capture", 32'h5FA0, rd_v)
		ctl_u.scan(1, {28'h0, `JTDR_OP_EXTEST}, 4, rd_v);
		`CHK("extest data", 8'h5A, pin_out)
		`CHK("extest oe", 8'hFF, pin_oe)
		// Boundary test keeps the pins even in reset, so leave it before pulling the reset pin
		ctl_u.scan(1, {28'h0, `JTDR_OP_BYPASS}, 4, rd_v);
		ext_reset_n = 1'b0;
		cyc(4);
		`CHK("pin reset", 1'b1, sys_reset)
		`CHK("pin reset hiz", 8'h00, pin_oe)
		ext_reset_n = 1'b1;
		cnt = 0;
		while (sys_reset === 1'b1 && cnt < 50)
		begin
			cyc(1);
			cnt++;
		end
		`CHK("stretch", 1'b1, cnt >= 4 && cnt <= 9)
	endtask : t_boundary

	task automatic t_enables();
		for (int m = 0; m < 16; m++)
		begin
			{test_port_enable_fuse, debug_enable_fuse, lock_bit_one, lock_bit_two} = m[3:0];
			cyc(2);
			`CHK("debug active", m == 12, debug_active)
		end
		debug_fuse_prog_req = 1'b1;
		lock_bit_one = 1'b1;
		cyc(2);
		`CHK("fuse locked", 1'b0, debug_fuse_prog_ok)
		{lock_bit_one, lock_bit_two} = 2'b00;
		cyc(2);
		`CHK("fuse still locked", 1'b0, debug_fuse_prog_ok)
		chip_erase = 1'b1;
		cyc(1);
		chip_erase = 1'b0;
		cyc(2);
		`CHK("fuse after erase", 1'b1, debug_fuse_prog_ok)
		test_port_disable_bit = 1'b1;
		oe_seen = 1'b0;
		ctl_u.scan(0, 32'h0, 32, rd_v);
		`CHK("port disabled", 1'b0, oe_seen)
	endtask : t_enables

	initial
	begin
		{jtdr_clk_unused_guard, test_port_disable_bit, lock_bit_one, lock_bit_two, oe_seen} = '0;
		{debugger_access_en, debugger_clear_dirty, debug_fuse_prog_req, chip_erase} = '0;
		{flow_change, step_done, break_flow_en, single_step_en, bp_hit, cpu} = '0;
		{test_port_enable_fuse, debug_enable_fuse, ext_reset_n, rst} = 4'hF;
		{reset_timeout, io_rdata, pin_in, core_out, core_oe} = {16'h0004, 8'hC3, 8'h3C, 8'h0F, 8'hF0};
		bp_mode = jtdr_pkg::BP_FOUR_PROG;
		cyc(4);
		rst = 1'b0;
		cyc(4);
		t_scan_paths();
		t_reset_reg();
		t_message();
		t_breaks();
		t_boundary();
		t_enables();
		tally_and_finish();
	end

	initial
	begin
		#2000000;
		n_errors++;
		tally_and_finish();
	end
endmodule : tb
